/* core/pefm_defines.svh */
// Purpose: Named constants for the phase event flag and mask block.
// Assumes: Plain register port with a 16-bit address and 32-bit data.
// Notes: Every offset and bit position used by the logic lives here, with the bus, current, threshold and checksum widths.
`ifndef PEFM_DEFINES_SVH
`define PEFM_DEFINES_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define PEFM_ADDR_W 16
`define PEFM_DATA_W 32
`define PEFM_ADDR_INTERRUPT_ENABLE_UPPER 16'hE50B
`define PEFM_ADDR_EVENT_STATUS_UPPER 16'hE503
`define PEFM_ADDR_PHSRC 16'hE600
`define PEFM_ADDR_PHNL 16'hE608
`define PEFM_ADDR_THRESH 16'h4398

// ****************************************************************
// Event bit positions shared by status and mask
// ****************************************************************
`define PEFM_B_TOTAL_POWER_IDLE_FLAG 0
`define PEFM_B_FUNDAMENTAL_POWER_IDLE_FLAG 1
`define PEFM_B_APPARENT_POWER_IDLE_FLAG 2
`define PEFM_B_RESET_COMPLETE_EVENT 15
`define PEFM_B_SAG 16
`define PEFM_B_OI 17
`define PEFM_B_OV 18
`define PEFM_B_SEQ 19
`define PEFM_B_MISM 20
`define PEFM_B_PKI 23
`define PEFM_B_PKV 24
`define PEFM_B_CRC 25

// Bits that exist in status and mask; all others read zero.
`define PEFM_EVT_BITS 32'h039F8007
// Bits of the mask that may raise the interrupt through the mask.
`define PEFM_MASK_GATE 32'h039F0007

// ****************************************************************
// Phase source and no-load fields, and widths
// ****************************************************************
`define PEFM_PH_OI_LSB 3
`define PEFM_PH_OV_LSB 9
`define PEFM_PH_VS_LSB 12
`define PEFM_NL_TOT_LSB 0
`define PEFM_NL_FUN_LSB 3
`define PEFM_NL_APP_LSB 6
`define PEFM_CUR_W 24
`define PEFM_THR_W 24
`define PEFM_CRC_W 32

`endif

/* core/pefm_pkg.sv */
// Purpose: Types for the phase event flag and mask block.
// Assumes: Constants come from pefm_defines.svh.
// Notes: Detector outputs travel as packed structs.
`include "pefm_defines.svh"

package pefm_pkg;

	// ****************************************************************
	// Detector carriers
	// ****************************************************************
	typedef struct packed {
		logic sag;
		logic overcurrent_event;
		logic high_voltage_event;
		logic current_peak_window_done;
		logic voltage_peak_window_done;
		logic [2:0] dip_source_phases;
		logic [2:0] overcurrent_source_phases;
		logic [2:0] high_voltage_source_phases;
	} pefm_ev_t;

	typedef struct packed {
		logic update;
		logic [2:0] total_power_idle_phases;
		logic [2:0] fundamental_power_idle_phases;
		logic [2:0] apparent_power_idle_phases;
	} pefm_nl_t;

	typedef enum logic [1:0] {
		PEFM_ROT_IDLE = 2'b01,
		PEFM_ROT_AFTER_A = 2'b10
	} pefm_rot_t;

endpackage

/* core/pefm_top.sv */
// Purpose: Event flags, upper interrupt enables and per-phase source reporting.
// Assumes: Detector inputs are single-cycle pulses on clk; no pin input here.
// Notes: Status flags are write-one-to-clear and a new event wins over a clear.
//
// Function
// RULE_01 - Mask bit 15 stores writes but never influences the interrupt.
// RULE_02 - Mask bit 16 enables the sag interrupt; dip phases are reported.
// RULE_03 - Mask bit 17 enables the overcurrent interrupt; source phases reported.
// RULE_04 - Mask bit 18 enables the overvoltage interrupt; source phases reported.
// RULE_05 - Mask bit 19 enables interrupt when A crossing is followed by C.
// RULE_06 - Mask bit 20 enables interrupt when neutral mismatch exceeds threshold.
// RULE_07 - Mask bit 23 enables interrupt at end of current peak window.
// RULE_08 - Mask bit 24 enables interrupt at end of voltage peak window.
// RULE_09 - Mask bit 25 enables interrupt when checksum differs from captured one.
// RULE_10 - Mask bits 21-22 and 26-31 are reserved, zero, without effect.
// RULE_11 - Phase status bits 3-5 show overcurrent source phases A, B, C.
// RULE_12 - Phase status bits 9-11 show overvoltage source phases A, B, C.
// RULE_13 - Phase status bits 12-14 show sag source phases A, B, C.
// RULE_14 - Phase status bits 0-2, 6-8 and 15 always read zero.
// RULE_15 - No-load bits 0-2 total power, set with status bit 0.
// RULE_16 - No-load bits 3-5 fundamental power, set with status bit 1.
// RULE_17 - No-load bits 6-8 apparent power, set with status bit 2.
// RULE_18 - No-load bits read zero when out of no-load, reset to zero.
// RULE_19 - No-load bits 9-15 always read zero.
// RULE_20 - Upper mask register sits at 0xE50B and resets to zero.
// RULE_21 - Mask bits 0-2 enable the three no-load entry interrupts.
// RULE_22 - Interrupt asserts for any masked set flag; reset-complete always.
//
// Decided for this implementation: the address-and-strobe port.
`include "pefm_defines.svh"

module pefm_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [`PEFM_ADDR_W-1:0] reg_addr,
	input wire logic [`PEFM_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`PEFM_DATA_W-1:0] reg_rdata,
	// Detector events
	input wire pefm_pkg::pefm_ev_t ev,
	input wire pefm_pkg::pefm_nl_t nl,
	// Rising voltage zero crossings
	input wire logic zx_rise_a,
	input wire logic zx_rise_b,
	input wire logic zx_rise_c,
	// Neutral current samples
	input wire logic [`PEFM_CUR_W-1:0] computed_current_sum,
	input wire logic [`PEFM_CUR_W-1:0] measured_neutral_current,
	input wire logic neutral_sample,
	// Configuration checksum
	input wire logic [`PEFM_CRC_W-1:0] checksum_value,
	input wire logic run_set,
	// Interrupt
	output logic irq
);
	import pefm_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	logic [`PEFM_DATA_W-1:0] mask_r;
	logic [`PEFM_DATA_W-1:0] status_r;
	logic [`PEFM_DATA_W-1:0] status_nxt;
	logic [15:0] phsrc_r;
	logic [15:0] phsrc_nxt;
	logic [15:0] phnl_r;
	logic [`PEFM_THR_W-1:0] thresh_r;
	logic [`PEFM_CRC_W-1:0] crc_ref_r;
	logic crc_armed_r;
	logic boot_done_r;
	logic irq_r;
	logic [`PEFM_DATA_W-1:0] rdata_r;
	pefm_rot_t rot_r;
	pefm_rot_t rot_nxt;

	// ****************************************************************
	// Register decode
	// ****************************************************************
	wire sel_mask = reg_addr == `PEFM_ADDR_INTERRUPT_ENABLE_UPPER;
	wire sel_status = reg_addr == `PEFM_ADDR_EVENT_STATUS_UPPER;
	wire sel_phsrc = reg_addr == `PEFM_ADDR_PHSRC;
	wire sel_phnl = reg_addr == `PEFM_ADDR_PHNL;
	wire sel_thresh = reg_addr == `PEFM_ADDR_THRESH;
	wire wr_mask = reg_wr & sel_mask;
	wire wr_status = reg_wr & sel_status;
	wire wr_thresh = reg_wr & sel_thresh;

	// ****************************************************************
	// Detectors
	// ****************************************************************
	// Sign-extended difference keeps a full-scale swing from wrapping.
	wire signed [`PEFM_CUR_W:0] neu_diff = $signed({computed_current_sum[`PEFM_CUR_W-1],
		computed_current_sum}) - $signed({measured_neutral_current[`PEFM_CUR_W-1],
		measured_neutral_current});
	wire [`PEFM_CUR_W:0] neu_abs = neu_diff[`PEFM_CUR_W] ? `PEFM_CUR_W'(0) - neu_diff :
		neu_diff;
	wire mism_hit = neutral_sample & (neu_abs > {1'b0, thresh_r}); // RULE_06
	wire crc_hit = crc_armed_r & (checksum_value != crc_ref_r); // RULE_09
	wire seq_hit = (rot_r == PEFM_ROT_AFTER_A) & zx_rise_c & ~zx_rise_b; // RULE_05

	// A phase newly entering no-load raises the flag; staying idle does not.
	wire [2:0] nl_tot_in = nl.total_power_idle_phases & ~phnl_r[`PEFM_NL_TOT_LSB +: 3];
	wire [2:0] nl_fun_in = nl.fundamental_power_idle_phases & ~phnl_r[`PEFM_NL_FUN_LSB +: 3];
	wire [2:0] nl_app_in = nl.apparent_power_idle_phases & ~phnl_r[`PEFM_NL_APP_LSB +: 3];
	wire nl_tot_hit = nl.update & (|nl_tot_in); // RULE_15
	wire nl_fun_hit = nl.update & (|nl_fun_in); // RULE_16
	wire nl_app_hit = nl.update & (|nl_app_in); // RULE_17

	// Event vector in status bit order.
	logic [`PEFM_DATA_W-1:0] ev_set;
	always_comb begin
		ev_set = '0;
		ev_set[`PEFM_B_TOTAL_POWER_IDLE_FLAG] = nl_tot_hit;
		ev_set[`PEFM_B_FUNDAMENTAL_POWER_IDLE_FLAG] = nl_fun_hit;
		ev_set[`PEFM_B_APPARENT_POWER_IDLE_FLAG] = nl_app_hit;
		ev_set[`PEFM_B_RESET_COMPLETE_EVENT] = ~boot_done_r;
		ev_set[`PEFM_B_SAG] = ev.sag; // RULE_02
		ev_set[`PEFM_B_OI] = ev.overcurrent_event; // RULE_03
		ev_set[`PEFM_B_OV] = ev.high_voltage_event; // RULE_04
		ev_set[`PEFM_B_SEQ] = seq_hit; // RULE_05
		ev_set[`PEFM_B_MISM] = mism_hit; // RULE_06
		ev_set[`PEFM_B_PKI] = ev.current_peak_window_done; // RULE_07
		ev_set[`PEFM_B_PKV] = ev.voltage_peak_window_done; // RULE_08
		ev_set[`PEFM_B_CRC] = crc_hit; // RULE_09
	end

	// Write one clears, but an event in the same cycle keeps its flag.
	wire [`PEFM_DATA_W-1:0] clr_vec = wr_status ? reg_wdata : '0;
	assign status_nxt = ((status_r & ~clr_vec) | ev_set) & `PEFM_EVT_BITS;

	// ****************************************************************
	// Phase source capture
	// ****************************************************************
	// Each source field reloads only on its own event so a later event on
	// another kind does not disturb it.
	always_comb begin
		phsrc_nxt = phsrc_r;
		if (ev.overcurrent_event) begin
			phsrc_nxt[`PEFM_PH_OI_LSB +: 3] = ev.overcurrent_source_phases; // RULE_11
		end
		if (ev.high_voltage_event) begin
			phsrc_nxt[`PEFM_PH_OV_LSB +: 3] = ev.high_voltage_source_phases; // RULE_12
		end
		if (ev.sag) begin
			phsrc_nxt[`PEFM_PH_VS_LSB +: 3] = ev.dip_source_phases; // RULE_13
		end
	end

	// ****************************************************************
	// Rotation order watcher
	// ****************************************************************
	always_comb begin
		rot_nxt = rot_r;
		unique case (rot_r)
			PEFM_ROT_IDLE: begin
				if (zx_rise_a) begin
					rot_nxt = PEFM_ROT_AFTER_A;
				end
			end
			PEFM_ROT_AFTER_A: begin
				if (zx_rise_b | zx_rise_c) begin
					rot_nxt = zx_rise_a ? PEFM_ROT_AFTER_A : PEFM_ROT_IDLE;
				end
			end
			default: begin
				rot_nxt = PEFM_ROT_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// Interrupt and read path
	// ****************************************************************
	wire [`PEFM_DATA_W-1:0] mask_gated = status_nxt & mask_r & `PEFM_MASK_GATE;
	wire irq_nxt = (|mask_gated) | status_nxt[`PEFM_B_RESET_COMPLETE_EVENT]; // RULE_22 RULE_01

	logic [`PEFM_DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (sel_mask) begin
			rd_mux = mask_r;
		end else if (sel_status) begin
			rd_mux = status_r;
		end else if (sel_phsrc) begin
			rd_mux = {16'h0000, phsrc_r}; // RULE_14
		end else if (sel_phnl) begin
			rd_mux = {16'h0000, phnl_r}; // RULE_19
		end else if (sel_thresh) begin
			rd_mux = {{(`PEFM_DATA_W-`PEFM_THR_W){1'b0}}, thresh_r};
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_r <= '0; // RULE_20
			thresh_r <= '0;
		end else begin
			if (wr_mask) begin
				mask_r <= reg_wdata & `PEFM_EVT_BITS; // RULE_10 RULE_21 RULE_01
			end
			if (wr_thresh) begin
				thresh_r <= reg_wdata[`PEFM_THR_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status_r <= '0;
			phsrc_r <= '0;
			boot_done_r <= 1'b0;
			rot_r <= PEFM_ROT_IDLE;
		end else begin
			status_r <= status_nxt;
			phsrc_r <= phsrc_nxt;
			boot_done_r <= 1'b1;
			rot_r <= rot_nxt;
		end
	end

	// No-load phase bits follow each update, so a phase leaving no-load reads 0.
	always_ff @(posedge clk) begin
		if (rst) begin
			phnl_r <= '0; // RULE_18
		end else if (nl.update) begin
			phnl_r <= {7'h00, nl.apparent_power_idle_phases, // RULE_17 RULE_19
				nl.fundamental_power_idle_phases, nl.total_power_idle_phases}; // RULE_15 RULE_16
		end
	end

	// The reference is retaken on every run request; the comparison starts after it.
	always_ff @(posedge clk) begin
		if (rst) begin
			crc_ref_r <= '0;
			crc_armed_r <= 1'b0;
		end else if (run_set) begin
			crc_ref_r <= checksum_value; // RULE_09
			crc_armed_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			irq_r <= irq_nxt;
			rdata_r <= reg_rd ? rd_mux : '0;
		end
	end

	assign irq = irq_r;
	assign reg_rdata = rdata_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_rot_a;
		zx_rise_a && rot_r == PEFM_ROT_IDLE;
	endsequence

	sequence s_rot_c_first;
		zx_rise_c && !zx_rise_b && rot_r == PEFM_ROT_AFTER_A;
	endsequence

	sequence s_rot_b_first;
		zx_rise_b && !zx_rise_c && !zx_rise_a;
	endsequence

	AST_IRQ_RESET_COMPLETE_EVENT: assert property ( // RULE_22
		status_r[`PEFM_B_RESET_COMPLETE_EVENT] |-> irq_r)
		else $error("reset-complete flag set without interrupt");

	AST_MASK15_INERT: assert property ( // RULE_01
		(status_r & $past(mask_r) & `PEFM_MASK_GATE) == '0 && !status_r[`PEFM_B_RESET_COMPLETE_EVENT]
		&& !$past(rst) |-> !irq_r)
		else $error("interrupt raised with no enabled flag");

	AST_SAG_IRQ: assert property ( // RULE_02
		ev.sag && mask_r[`PEFM_B_SAG] && !wr_mask |=> irq_r && status_r[`PEFM_B_SAG]
		&& phsrc_r[`PEFM_PH_VS_LSB +: 3] == $past(ev.dip_source_phases))
		else $error("sag event not reported");

	AST_OI_SRC: assert property ( // RULE_03 RULE_11
		ev.overcurrent_event |=> status_r[`PEFM_B_OI]
		&& phsrc_r[`PEFM_PH_OI_LSB +: 3] == $past(ev.overcurrent_source_phases))
		else $error("overcurrent source not captured");

	AST_OV_SRC: assert property ( // RULE_04 RULE_12
		ev.high_voltage_event |=> status_r[`PEFM_B_OV]
		&& phsrc_r[`PEFM_PH_OV_LSB +: 3] == $past(ev.high_voltage_source_phases))
		else $error("overvoltage source not captured");

	AST_ROT_FAULT: assert property ( // RULE_05
		s_rot_a ##1 (!zx_rise_b && !zx_rise_c) [*1] ##1 s_rot_c_first
		|=> status_r[`PEFM_B_SEQ])
		else $error("rotation fault missed");

	AST_ROT_GOOD: assert property ( // RULE_05
		s_rot_a ##1 (!zx_rise_b && !zx_rise_c) [*1] ##1 s_rot_b_first
		##1 (!zx_rise_a && !zx_rise_b) [*1] ##1 zx_rise_c |-> !seq_hit)
		else $error("rotation fault on correct order");

	AST_MISMATCH: assert property ( // RULE_06
		neutral_sample && neu_abs > {1'b0, thresh_r} |=> status_r[`PEFM_B_MISM])
		else $error("neutral mismatch not flagged");

	AST_PEAK: assert property ( // RULE_07
		ev.current_peak_window_done |=> status_r[`PEFM_B_PKI])
		else $error("current peak window end not flagged");

	AST_PEAK_V: assert property ( // RULE_08
		ev.voltage_peak_window_done |=> status_r[`PEFM_B_PKV])
		else $error("voltage peak window end not flagged");

	AST_CRC: assert property ( // RULE_09
		run_set ##1 (!run_set && checksum_value != $past(checksum_value))
		|=> status_r[`PEFM_B_CRC])
		else $error("checksum change not flagged");

	AST_MASK_RESV: assert property ( // RULE_10 RULE_20
		(mask_r & ~`PEFM_EVT_BITS) == '0 && (status_r & ~`PEFM_EVT_BITS) == '0)
		else $error("reserved mask or status bit set");

	AST_PHSRC_RESV: assert property ( // RULE_14
		phsrc_r[`PEFM_PH_OI_LSB-1:0] == '0
		&& phsrc_r[`PEFM_PH_OV_LSB-1:`PEFM_PH_OI_LSB+3] == '0
		&& !phsrc_r[`PEFM_PH_VS_LSB+3])
		else $error("reserved phase status bit set");

	AST_NOLOAD: assert property ( // RULE_15 RULE_16 RULE_17 RULE_18
		nl.update |=> phnl_r[8:0] == $past({nl.apparent_power_idle_phases,
		nl.fundamental_power_idle_phases, nl.total_power_idle_phases})
		&& (status_r[2:0] & $past({nl_app_hit, nl_fun_hit, nl_tot_hit}))
		== $past({nl_app_hit, nl_fun_hit, nl_tot_hit}))
		else $error("no-load bits and flags disagree");

	AST_NL_RESV: assert property ( // RULE_19
		reg_rd && sel_phnl |=> reg_rdata[`PEFM_DATA_W-1:`PEFM_NL_APP_LSB+3] == '0)
		else $error("reserved no-load bit read as one");

	AST_NL_MASK: assert property ( // RULE_21
		nl_tot_hit && mask_r[`PEFM_B_TOTAL_POWER_IDLE_FLAG] && !wr_mask |=> irq_r)
		else $error("no-load interrupt missing");

	AST_SET_WINS: assert property ( // RULE_22
		ev.sag && wr_status && reg_wdata[`PEFM_B_SAG] |=> status_r[`PEFM_B_SAG])
		else $error("clear beat a simultaneous event");

	AST_READ_MASK: assert property ( // RULE_20
		reg_rd && sel_mask && !$past(wr_mask) |=> reg_rdata == $past(mask_r, 1))
		else $error("mask readback wrong");

	AST_W1C_OI: assert property ( // RULE_03
		wr_status && reg_wdata[`PEFM_B_OI] && !ev.overcurrent_event |=> !status_r[`PEFM_B_OI])
		else $error("overcurrent flag not cleared by write");

	AST_CRC_IDLE: assert property ( // RULE_09
		!crc_armed_r && !status_r[`PEFM_B_CRC] |=> !status_r[`PEFM_B_CRC])
		else $error("checksum flag set before any run request");

	AST_DIP_HOLD: assert property ( // RULE_13
		!ev.sag |=> phsrc_r[`PEFM_PH_VS_LSB +: 3] == $past(phsrc_r[`PEFM_PH_VS_LSB +: 3]))
		else $error("dip source field moved without a sag event");

	AST_NL_QUIET: assert property ( // RULE_18
		!nl.update |=> phnl_r == $past(phnl_r))
		else $error("no-load bits moved without an update");

endmodule

/* verification/pefm_top_tb.sv */
// Purpose: Self-checking bench for the phase event flag and mask block.
// Assumes: Read data stand only in the cycle after the read strobe; events are one-cycle pulses.
// Notes: Each scenario clears the flags and enables it raised before it returns.
`include "pefm_defines.svh"

module pefm_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import pefm_pkg::*;

	// ****************************************************************
	// Signals and design
	// ****************************************************************
	localparam logic [15:0] A_MASK = `PEFM_ADDR_INTERRUPT_ENABLE_UPPER;
	localparam logic [15:0] A_ST = `PEFM_ADDR_EVENT_STATUS_UPPER;
	localparam logic [15:0] A_SRC = `PEFM_ADDR_PHSRC;
	localparam logic [15:0] A_NL = `PEFM_ADDR_PHNL;
	logic clk;
	logic rst;
	logic [`PEFM_ADDR_W-1:0] reg_addr;
	logic [`PEFM_DATA_W-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [`PEFM_DATA_W-1:0] reg_rdata;
	pefm_ev_t ev;
	pefm_nl_t nl;
	logic zx_rise_a, zx_rise_b, zx_rise_c;
	logic [`PEFM_CUR_W-1:0] computed_current_sum;
	logic [`PEFM_CUR_W-1:0] measured_neutral_current;
	logic neutral_sample;
	logic [`PEFM_CRC_W-1:0] checksum_value;
	logic run_set;
	logic irq;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	logic [15:0] src_exp = 16'h0;
	int ev_bit[5] = '{16, 17, 18, 23, 24};
	int ev_lsb[5] = '{12, 3, 9, -1, -1};

	pefm_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev(ev), .nl(nl),
		.zx_rise_a(zx_rise_a), .zx_rise_b(zx_rise_b), .zx_rise_c(zx_rise_c),
		.computed_current_sum(computed_current_sum),
		.measured_neutral_current(measured_neutral_current),
		.neutral_sample(neutral_sample), .checksum_value(checksum_value),
		.run_set(run_set), .irq(irq));

	// ****************************************************************
	// Clock, timeout and closing report
	// ****************************************************************
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// The whole run needs well under two thousand cycles, so this only cuts a hang short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	// Read data are taken one step after the edge that registers them.
	task automatic expect_reg(input string what, input logic [15:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk(what, reg_rdata, exp);
	endtask

	// The interrupt may follow a mask change one cycle late, so two edges are allowed.
	task automatic check_irq(input logic exp);
		repeat (2) @(posedge clk);
		#1;
		chk("irq", {31'h0, irq}, {31'h0, exp});
	endtask

	task automatic pulse_ev(input int k, input logic [2:0] ph);
		@(posedge clk);
		ev <= {5'h10 >> k, ph, ph, ph};
		@(posedge clk);
		ev <= {5'h0, ph, ph, ph};
	endtask

	task automatic zx_pulse(input logic [2:0] p);
		@(posedge clk);
		{zx_rise_c, zx_rise_b, zx_rise_a} <= p;
		@(posedge clk);
		{zx_rise_c, zx_rise_b, zx_rise_a} <= 3'h0;
	endtask

	task automatic neutral_check(input logic [23:0] s, input logic [23:0] n);
		@(posedge clk);
		computed_current_sum <= s;
		measured_neutral_current <= n;
		neutral_sample <= 1'h1;
		@(posedge clk);
		neutral_sample <= 1'h0;
	endtask

	task automatic nl_update(input logic [8:0] v);
		@(posedge clk);
		nl <= {1'h1, v};
		@(posedge clk);
		nl.update <= 1'h0;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_reset();
		repeat (3) @(posedge clk);
		#1;
		chk("irq after reset", {31'h0, irq}, 32'h1);
		expect_reg("status", A_ST, 32'h8000);
		expect_reg("mask", A_MASK, 32'h0);
		expect_reg("phase source", A_SRC, 32'h0);
		expect_reg("no load", A_NL, 32'h0);
		expect_reg("unmapped", 16'h1234, 32'h0);
		reg_write(A_ST, 32'h8000);
		check_irq(1'h0);
	endtask

	task automatic test_mask();
		reg_write(A_MASK, 32'hFFFF_FFFF);
		expect_reg("mask", A_MASK, `PEFM_EVT_BITS);
		reg_write(A_MASK, 32'h0000_8000);
		expect_reg("mask", A_MASK, 32'h0000_8000);
		pulse_ev(0, 3'h0);
		check_irq(1'h0);
		reg_write(A_ST, 32'hFFFF_FFFF);
		reg_write(A_SRC, 32'hFFFF_FFFF);
		reg_write(A_NL, 32'hFFFF_FFFF);
		expect_reg("phase source", A_SRC, 32'h0);
		expect_reg("no load", A_NL, 32'h0);
		reg_write(A_MASK, 32'h0);
	endtask

	// Each event carries a different phase pattern so that a field loaded by the wrong event shows.
	task automatic test_events();
		int b;
		logic [2:0] ph;
		for (int k = 0; k < 5; k++) begin
			b = ev_bit[k];
			ph = 3'(k + 1);
			pulse_ev(k, ph);
			check_irq(1'h0);
			expect_reg("status", A_ST, 32'h1 << b);
			if (ev_lsb[k] >= 0) begin
				src_exp[ev_lsb[k] +: 3] = ph;
			end
			expect_reg("phase source", A_SRC, {16'h0, src_exp});
			reg_write(A_MASK, 32'h1 << b);
			check_irq(1'h1);
			reg_write(A_ST, 32'h1 << b);
			check_irq(1'h0);
		end
		reg_write(A_MASK, 32'h0);
		// A clear that meets a new event in the same cycle must leave the flag set.
		fork
			pulse_ev(0, 3'h4);
			reg_write(A_ST, 32'h1 << `PEFM_B_SAG);
		join
		expect_reg("status", A_ST, 32'h1 << `PEFM_B_SAG);
		reg_write(A_ST, 32'h1 << `PEFM_B_SAG);
	endtask

	task automatic test_rotation();
		reg_write(A_MASK, 32'h1 << `PEFM_B_SEQ);
		zx_pulse(3'h1);
		zx_pulse(3'h2);
		zx_pulse(3'h4);
		check_irq(1'h0);
		expect_reg("status", A_ST, 32'h0);
		zx_pulse(3'h1);
		zx_pulse(3'h4);
		check_irq(1'h1);
		expect_reg("status", A_ST, 32'h1 << `PEFM_B_SEQ);
		reg_write(A_ST, 32'hFFFF_FFFF);
		reg_write(A_MASK, 32'h0);
	endtask

	// A difference equal to the threshold must not count; the first pair is negative.
	task automatic test_mismatch();
		reg_write(`PEFM_ADDR_THRESH, 32'h64);
		expect_reg("threshold", `PEFM_ADDR_THRESH, 32'h64);
		neutral_check(24'hFFFFCE, 24'h32);
		expect_reg("status", A_ST, 32'h0);
		neutral_check(24'h12C, 24'hC7);
		expect_reg("status", A_ST, 32'h1 << `PEFM_B_MISM);
		reg_write(A_MASK, 32'h1 << `PEFM_B_MISM);
		check_irq(1'h1);
		reg_write(A_ST, 32'hFFFF_FFFF);
		reg_write(A_MASK, 32'h0);
	endtask

	task automatic test_checksum();
		@(posedge clk);
		checksum_value <= 32'hA5A5_0F0F;
		run_set <= 1'h1;
		@(posedge clk);
		run_set <= 1'h0;
		repeat (4) @(posedge clk);
		expect_reg("status", A_ST, 32'h0);
		@(posedge clk);
		checksum_value <= 32'hA5A5_0F0E;
		expect_reg("status", A_ST, 32'h1 << `PEFM_B_CRC);
		reg_write(A_MASK, 32'h1 << `PEFM_B_CRC);
		check_irq(1'h1);
		@(posedge clk);
		checksum_value <= 32'hA5A5_0F0F;
		reg_write(A_ST, 32'hFFFF_FFFF);
		check_irq(1'h0);
		// A change right after a fresh run request must be caught as well.
		@(posedge clk);
		run_set <= 1'h1;
		@(posedge clk);
		run_set <= 1'h0;
		checksum_value <= 32'h0000_0001;
		check_irq(1'h1);
		@(posedge clk);
		checksum_value <= 32'hA5A5_0F0F;
		reg_write(A_ST, 32'hFFFF_FFFF);
		reg_write(A_MASK, 32'h0);
	endtask

	task automatic test_noload();
		reg_write(A_MASK, 32'h1);
		nl_update({3'h5, 3'h2, 3'h6});
		check_irq(1'h1);
		expect_reg("no load", A_NL, 32'h195);
		expect_reg("status", A_ST, 32'h7);
		reg_write(A_ST, 32'h1);
		check_irq(1'h0);
		reg_write(A_MASK, 32'h6);
		check_irq(1'h1);
		nl_update(9'h0);
		expect_reg("no load", A_NL, 32'h0);
		reg_write(A_ST, 32'hFFFF_FFFF);
		check_irq(1'h0);
		reg_write(A_MASK, 32'h0);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		rst = 1'h1;
		reg_addr = 16'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		ev = '0;
		nl = '0;
		{zx_rise_c, zx_rise_b, zx_rise_a} = 3'h0;
		computed_current_sum = 24'h0;
		measured_neutral_current = 24'h0;
		neutral_sample = 1'h0;
		checksum_value = 32'h0;
		run_set = 1'h0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		test_reset();
		test_mask();
		test_events();
		test_rotation();
		test_mismatch();
		test_checksum();
		test_noload();
		end_sim();
	end
endmodule
